//--- hdl/dual_timer_defs.vh
// Register offsets, bit positions, reset values and timing counts of the dual timer.
`ifndef DUAL_TIMER_DEFS_VH
`define DUAL_TIMER_DEFS_VH

// Register offsets on the 4-bit register port.
`define OFS_MODE_SELECT 4'h0
`define OFS_RUN_FLAGS 4'h1
`define OFS_LOW_BYTE0 4'h2
`define OFS_HIGH_BYTE0 4'h3
`define OFS_LOW_BYTE1 4'h4
`define OFS_HIGH_BYTE1 4'h5
`define OFS_IRQ_STATUS 4'h6
`define OFS_IRQ_CLEAR 4'h7
`define OFS_IRQ_ENABLE 4'h8

// Mode register fields, per unit nibble.
`define MODE_GATE_BIT 3
`define MODE_CT_BIT 2
`define MODE_UPPER_BIT 1
`define MODE_LOWER_BIT 0

// Run and flags register bits.
`define RF_OVF1 7
`define RF_RUN1 6
`define RF_OVF0 5
`define RF_RUN0 4
`define RF_EXT1 3
`define RF_TYPE1 2
`define RF_EXT0 1
`define RF_TYPE0 0

// Interrupt status bits: overflow 0, overflow 1, external 0, external 1.
`define IRQ_OVF0 0
`define IRQ_OVF1 1
`define IRQ_EXT0 2
`define IRQ_EXT1 3

// Mode field encodings.
`define MODE_13BIT 2'h0
`define MODE_16BIT 2'h1
`define MODE_RELOAD8 2'h2
`define MODE_SPLIT8 2'h3

// Reset values.
`define RST_MODE_SELECT 8'h00
`define RST_RUN_FLAGS 8'h00
`define RST_IRQ_ENABLE 4'h0

// Timing: core clocks per machine cycle.
`define CLOCKS_PER_MACHINE_CYCLE 4'hC
`define MACHINE_CYCLE_LAST 4'hB

`endif

//--- hdl/dual_timer_counter_block.v
// Dual up-counting timer/counter with four modes, external gating and a register port.
//
// What this block does
// - Timer mode counts once per twelve clocks.
// - Counter mode counts falling edges of count input.
// - Edge recognition takes two machine cycles.
// - Two independent 16-bit units, low and high byte.
// - Gate bit makes counting need pin high.
// - Select bit one counts edges, zero times.
// - Two-bit mode field per unit.
// - Mode 0 thirteen bits, mode 1 sixteen.
// - Mode 2 reloads low byte from high.
// - Mode 3 halts unit 1, splits unit 0.
// - Split bytes use run0/gate and run1 respectively.
// - Run bits start and stop units.
// - Overflow sets flag; software or acknowledge clears.
// - Pin falling edge sets external flag.
// - Type bit chooses edge or level trigger.

`include "dual_timer_defs.vh"

module dual_timer_counter_block (
  input wire mclk,
  input wire resetn,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire count_input_unit0,
  input wire count_input_unit1,
  input wire ext_interrupt_pin_a,
  input wire ext_interrupt_pin_b,
  input wire ack_overflow0,
  input wire ack_overflow1,
  input wire ack_ext0,
  input wire ack_ext1,
  output wire ext_request0,
  output wire ext_request1,
  output wire irq
);

  // Register map seen from the register port, one byte per offset.
  // Offset 0 holds the mode select byte; its upper nibble configures unit 1.
  // Offset 1 holds run bits, overflow flags, edge flags and trigger types.
  // Offsets 2 to 5 hold the low and high counter bytes of both units.
  // Offset 6 is the sticky interrupt status and is read only.
  // Offset 7 clears status bits by writing ones and always reads zero.
  // Offset 8 enables the status bits onto the single interrupt output.
  // Counter bytes are read one at a time with no latching of the pair.
  // Software reading a running 16-bit count must handle a carry between reads.
  // Writes that hit an unmapped offset are ignored without any side effect.
  //
  // Register state.
  reg [7:0] timer_mode_select_reg;
  reg [7:0] timer_run_and_flags_reg;
  reg [7:0] low_byte_unit0_reg;
  reg [7:0] high_byte_unit0_reg;
  reg [7:0] low_byte_unit1_reg;
  reg [7:0] high_byte_unit1_reg;
  reg [3:0] irq_status_reg;
  reg [3:0] irq_enable_reg;
  reg [3:0] mc_count_reg;
  reg [1:0] count_samp0_reg;
  reg [1:0] count_samp1_reg;
  reg ext_prev_a_reg;
  reg ext_prev_b_reg;

  // Decoded mode fields, upper nibble for unit 1, lower for unit 0.
  wire [3:0] cfg1 = timer_mode_select_reg[7:4];
  wire [3:0] cfg0 = timer_mode_select_reg[3:0];
  wire [1:0] mode1 = {cfg1[`MODE_UPPER_BIT], cfg1[`MODE_LOWER_BIT]};
  wire [1:0] mode0 = {cfg0[`MODE_UPPER_BIT], cfg0[`MODE_LOWER_BIT]};
  wire run0 = timer_run_and_flags_reg[`RF_RUN0];
  wire run1 = timer_run_and_flags_reg[`RF_RUN1];

  // Register port decode.
  wire wr_mode = reg_write && (reg_addr == `OFS_MODE_SELECT);
  wire wr_flags = reg_write && (reg_addr == `OFS_RUN_FLAGS);
  wire wr_tl0 = reg_write && (reg_addr == `OFS_LOW_BYTE0);
  wire wr_th0 = reg_write && (reg_addr == `OFS_HIGH_BYTE0);
  wire wr_tl1 = reg_write && (reg_addr == `OFS_LOW_BYTE1);
  wire wr_th1 = reg_write && (reg_addr == `OFS_HIGH_BYTE1);
  wire wr_iclr = reg_write && (reg_addr == `OFS_IRQ_CLEAR);
  wire wr_ien = reg_write && (reg_addr == `OFS_IRQ_ENABLE);

  // The step function is shared by both units, so the mode decoding lives once.
  // Mode 0 chains five low bits into the high byte for a 13-bit count.
  // Mode 1 uses the full sixteen bits and wraps to zero on overflow.
  // Mode 2 counts the low byte alone and reloads it from the high byte.
  // Mode 3 is handled outside the function, because it splits unit 0.
  // The top bit of the result marks an overflow in the stepping cycle.
  // An overflow is only reported when the unit really advanced that cycle.
  //
  // One advance step of a unit in modes 0 to 2: {overflow, high, low}.
  function [16:0] unit_step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg [13:0] sum13;
    reg [16:0] sum16;
    begin
      sum13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      sum16 = {1'b0, hi, lo} + 17'h00001;
      case (mode)
        `MODE_13BIT:
        begin
          // Five low bits plus the high byte; top three low bits held at zero.
          unit_step = {sum13[13], sum13[12:5], 3'h0, sum13[4:0]};
        end
        `MODE_16BIT:
        begin
          unit_step = sum16;
        end
        `MODE_RELOAD8:
        begin
          // Low byte overflow copies the high byte in as reload.
          if (lo == 8'hFF)
            unit_step = {1'b1, hi, hi};
          else
            unit_step = {1'b0, hi, lo + 8'h01};
        end
        default:
        begin
          unit_step = {1'b0, hi, lo};
        end
      endcase
    end
  endfunction

  // All counting advances on a single-cycle enable pulse from this divider.
  // Keeping one clock avoids any crossing between timing domains.
  // The divider free-runs from reset and is never restarted by software.
  // Because of that, the first tick after a run bit is set may come early.
  // A user who needs exact intervals must allow one machine cycle of slack.
  //
  // Machine cycle divider: one tick every twelve clocks.
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      mc_count_reg <= 4'h0;
    else if (mc_count_reg == `MACHINE_CYCLE_LAST)
      mc_count_reg <= 4'h0;
    else
      mc_count_reg <= mc_count_reg + 4'h1;
  end

  wire mc_tick = (mc_count_reg == `MACHINE_CYCLE_LAST);

  // Sampling only at ticks can miss pulses shorter than a machine cycle.
  // The pin sample registers reset high, matching the idle level of the pins.
  // This keeps a false falling edge from appearing right after reset.
  // The count samples reset low; a fall needs an older one and a newer zero.
  // An early low-to-high sample pair therefore never counts as an edge.
  //
  // Count inputs and interrupt pins are sampled once per machine cycle.
  // The source must hold each level for one machine cycle to be seen.
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_samp0_reg <= 2'h0;
      count_samp1_reg <= 2'h0;
      ext_prev_a_reg <= 1'b1;
      ext_prev_b_reg <= 1'b1;
    end
    else if (mc_tick)
    begin
      count_samp0_reg <= {count_samp0_reg[0], count_input_unit0};
      count_samp1_reg <= {count_samp1_reg[0], count_input_unit1};
      ext_prev_a_reg <= ext_interrupt_pin_a;
      ext_prev_b_reg <= ext_interrupt_pin_b;
    end
  end

  // A one-to-zero seen across two successive machine-cycle samples.
  wire fall0 = count_samp0_reg[1] & ~count_samp0_reg[0];
  wire fall1 = count_samp1_reg[1] & ~count_samp1_reg[0];
  wire ext_fall_a = mc_tick & ext_prev_a_reg & ~ext_interrupt_pin_a;
  wire ext_fall_b = mc_tick & ext_prev_b_reg & ~ext_interrupt_pin_b;

  // Enable: run bit set and, with gating, the interrupt pin high.
  wire en0 = run0 & (~cfg0[`MODE_GATE_BIT] | ext_interrupt_pin_a);
  wire en1 = run1 & (~cfg1[`MODE_GATE_BIT] | ext_interrupt_pin_b);

  // Per-tick advance: edge when counting, every machine cycle when timing.
  wire inc0 = mc_tick & en0 & (cfg0[`MODE_CT_BIT] ? fall0 : 1'b1);
  wire inc1 = mc_tick & en1 & (cfg1[`MODE_CT_BIT] ? fall1 : 1'b1);
  // In split mode the high byte of unit 0 times machine cycles under run bit 1.
  wire split0 = (mode0 == `MODE_SPLIT8);
  wire inc_th0 = mc_tick & run1;

  wire [16:0] step0 = unit_step(mode0, high_byte_unit0_reg, low_byte_unit0_reg);
  wire [16:0] step1 = unit_step(mode1, high_byte_unit1_reg, low_byte_unit1_reg);
  wire [8:0] split_lo = {1'b0, low_byte_unit0_reg} + 9'h001;
  wire [8:0] split_hi = {1'b0, high_byte_unit0_reg} + 9'h001;

  // Overflow events of both units.
  wire ovf0_evt = split0 ? (inc0 & split_lo[8]) : (inc0 & step0[16]);
  wire ovf1_split = split0 & inc_th0 & split_hi[8];
  // Unit 1 halts in mode 3, and loses its flag to unit 0's high byte when split.
  wire run_unit1 = inc1 & (mode1 != `MODE_SPLIT8);
  wire ovf1_evt = ovf1_split | (run_unit1 & step1[16] & ~split0);

  // Unit 0 byte registers; a write from the port takes precedence.
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_byte_unit0_reg <= 8'h00;
      high_byte_unit0_reg <= 8'h00;
    end
    else
    begin
      if (wr_tl0)
        low_byte_unit0_reg <= reg_wdata;
      else if (split0 && inc0)
        low_byte_unit0_reg <= split_lo[7:0];
      else if (!split0 && inc0)
        low_byte_unit0_reg <= step0[7:0];
      if (wr_th0)
        high_byte_unit0_reg <= reg_wdata;
      else if (split0 && inc_th0)
        high_byte_unit0_reg <= split_hi[7:0];
      else if (!split0 && inc0)
        high_byte_unit0_reg <= step0[15:8];
    end
  end

  // Unit 1 byte registers; mode 3 holds the value.
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      low_byte_unit1_reg <= 8'h00;
      high_byte_unit1_reg <= 8'h00;
    end
    else
    begin
      if (wr_tl1)
        low_byte_unit1_reg <= reg_wdata;
      else if (run_unit1)
        low_byte_unit1_reg <= step1[7:0];
      if (wr_th1)
        high_byte_unit1_reg <= reg_wdata;
      else if (run_unit1)
        high_byte_unit1_reg <= step1[15:8];
    end
  end

  // Mode register.
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      timer_mode_select_reg <= `RST_MODE_SELECT;
    else if (wr_mode)
      timer_mode_select_reg <= reg_wdata;
  end

  // External flag set: falling edge when type is one, low level when zero.
  wire ext_set0 = timer_run_and_flags_reg[`RF_TYPE0] ? ext_fall_a
                  : ~ext_interrupt_pin_a;
  wire ext_set1 = timer_run_and_flags_reg[`RF_TYPE1] ? ext_fall_b
                  : ~ext_interrupt_pin_b;

  // The flags register merges three writers: software, acknowledges and events.
  // Software may both set and clear every bit, the flags included.
  // An acknowledge from the interrupt controller clears one flag only.
  // Hardware events are applied last, so an event is never lost to a clear.
  // With level triggering the edge flag is set again every cycle the pin is low.
  // Clearing it therefore only sticks once the pin has returned high.
  //
  // Next value of the run and flags register: software write or acknowledge
  // clears a flag, but a hardware set in the same cycle wins.
  reg [7:0] run_flags_next;
  always @*
  begin
    run_flags_next = timer_run_and_flags_reg;
    if (wr_flags)
      run_flags_next = reg_wdata;
    if (ack_overflow0)
      run_flags_next[`RF_OVF0] = 1'b0;
    if (ack_overflow1)
      run_flags_next[`RF_OVF1] = 1'b0;
    if (ack_ext0)
      run_flags_next[`RF_EXT0] = 1'b0;
    if (ack_ext1)
      run_flags_next[`RF_EXT1] = 1'b0;
    if (ovf0_evt)
      run_flags_next[`RF_OVF0] = 1'b1;
    if (ovf1_evt)
      run_flags_next[`RF_OVF1] = 1'b1;
    if (ext_set0)
      run_flags_next[`RF_EXT0] = 1'b1;
    if (ext_set1)
      run_flags_next[`RF_EXT1] = 1'b1;
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      timer_run_and_flags_reg <= `RST_RUN_FLAGS;
    else
      timer_run_and_flags_reg <= run_flags_next;
  end

  // Edge flags carry the external requests to the interrupt controller.
  assign ext_request0 = timer_run_and_flags_reg[`RF_EXT0];
  assign ext_request1 = timer_run_and_flags_reg[`RF_EXT1];

  // Sticky status of block events; clear register writes ones to clear.
  wire [3:0] irq_events;
  assign irq_events[`IRQ_OVF0] = ovf0_evt;
  assign irq_events[`IRQ_OVF1] = ovf1_evt;
  assign irq_events[`IRQ_EXT0] = ext_set0 & ~timer_run_and_flags_reg[`RF_EXT0];
  assign irq_events[`IRQ_EXT1] = ext_set1 & ~timer_run_and_flags_reg[`RF_EXT1];

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_status_reg <= 4'h0;
      irq_enable_reg <= `RST_IRQ_ENABLE;
    end
    else
    begin
      // A set in the clearing cycle is kept.
      irq_status_reg <= (irq_status_reg & ~(wr_iclr ? reg_wdata[3:0] : 4'h0))
                        | irq_events;
      if (wr_ien)
        irq_enable_reg <= reg_wdata[3:0];
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  // The read data register only loads on a read strobe.
  // Between reads it keeps the last answer, which software must not rely on.
  // The clear register has no storage and reads back as zero.
  // Status and enable registers are four bits wide and read zero above.
  // Reading never changes any state, so reads have no side effects.
  //
  // Read data appear in the cycle after the read strobe; unmapped reads zero.
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      case (reg_addr)
        `OFS_MODE_SELECT: reg_rdata <= timer_mode_select_reg;
        `OFS_RUN_FLAGS: reg_rdata <= timer_run_and_flags_reg;
        `OFS_LOW_BYTE0: reg_rdata <= low_byte_unit0_reg;
        `OFS_HIGH_BYTE0: reg_rdata <= high_byte_unit0_reg;
        `OFS_LOW_BYTE1: reg_rdata <= low_byte_unit1_reg;
        `OFS_HIGH_BYTE1: reg_rdata <= high_byte_unit1_reg;
        `OFS_IRQ_STATUS: reg_rdata <= {4'h0, irq_status_reg};
        `OFS_IRQ_ENABLE: reg_rdata <= {4'h0, irq_enable_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // dual_timer_counter_block

//--- tb/dual_timer_counter_block_props.sv
// Port-level checks for the dual timer counter block.
module dual_timer_counter_block_props (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic ack_ext0,
  input wire logic ext_request0,
  input wire logic ext_request1,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // Register port answers and the request and interrupt outputs.
  chk_reset_quiet: assert property ($rose(resetn) |-> !irq && !ext_request0)
    else $error("outputs active after reset");
  chk_unmapped_zero: assert property (reg_read && reg_addr > 4'h8 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_clear_reads: assert property (reg_read && reg_addr == 4'h7 |=> reg_rdata == 8'h00)
    else $error("clear register read not zero");
  chk_mode_back: assert property (reg_write && reg_addr == 4'h0 ##1 reg_read && reg_addr == 4'h0
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("mode readback wrong");
  chk_run_back: assert property (reg_write && reg_addr == 4'h1 ##1 reg_read && reg_addr == 4'h1
    |=> (reg_rdata & 8'h50) == ($past(reg_wdata, 2) & 8'h50)) else $error("run bits wrong");
  chk_edge_req0: assert property (reg_write && reg_addr == 4'h1 && reg_wdata[1] && !ack_ext0
    |=> ext_request0) else $error("request 0 not set");
  chk_edge_req1: assert property (reg_write && reg_addr == 4'h1 && reg_wdata[3] |=> ext_request1)
    else $error("request 1 not set");
  chk_irq_masked: assert property (reg_write && reg_addr == 4'h8 && reg_wdata[3:0] == 4'h0
    |=> !irq) else $error("irq high while masked");
  // Main scenarios reached.
  cover property ($rose(irq));
  cover property ($fell(ext_request0));
  cover property (reg_read && reg_addr == 4'h6);
endmodule // dual_timer_counter_block_props

bind dual_timer_counter_block dual_timer_counter_block_props i_props (.mclk(mclk),
  .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .ack_ext0(ack_ext0),
  .ext_request0(ext_request0), .ext_request1(ext_request1), .irq(irq));

//--- tb/pin_source.sv
// Behavioural model of the external count and gate pins.
module pin_source (
  input wire logic mclk,
  input wire logic go,
  input wire logic [7:0] n,
  input wire logic gate_a,
  output logic count0 = 1'b1,
  output logic count1,
  output logic pin_a = 1'b1,
  output logic pin_b,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  int k = 0;
  // Sends n pulses; each level is held twelve clocks, one machine cycle.
  always @(posedge mclk)
  begin
    k <= go ? n * 24 : (k > 0 ? k - 1 : 0);
    count0 <= (k == 0) || ((k - 1) % 24 >= 12);
    pin_a <= gate_a;
  end
  // Unit 1 pins rest high.
  assign count1 = 1'b1;
  assign pin_b = 1'b1;
  assign busy = (k != 0);
endmodule // pin_source

//--- tb/dual_timer_counter_block_tb.sv
// Self-checking bench for the dual timer counter block.
module dual_timer_counter_block_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic ack_ovf0 = 1'b0;
  logic ack_ext0 = 1'b0;
  logic go = 1'b0;
  logic gate_a = 1'b1;
  logic [7:0] npulse = 8'h01;
  logic [7:0] rv;
  logic [7:0] q[$];
  logic rd_d = 1'b0;
  wire logic [7:0] reg_rdata;
  wire logic c0, c1, pa, pb, busy, req0, req1, irq;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int seed = 47;

  dual_timer_counter_block i_dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .count_input_unit0(c0), .count_input_unit1(c1),
    .ext_interrupt_pin_a(pa), .ext_interrupt_pin_b(pb), .ack_overflow0(ack_ovf0),
    .ack_overflow1(1'b0), .ack_ext0(ack_ext0), .ack_ext1(1'b0),
    .ext_request0(req0), .ext_request1(req1), .irq(irq));
  pin_source i_pins (.mclk(mclk), .go(go), .n(npulse), .gate_a(gate_a), .count0(c0),
    .count1(c1), .pin_a(pa), .pin_b(pb), .busy(busy));

  always #20 mclk = ~mclk;

  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [7:0] e);
    q.push_back(e);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
  endtask

  // Write followed at once by a read of the same place.
  task wr_rd(input logic [3:0] a, input logic [7:0] d);
    q.push_back(d);
    wr(a, d);
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
  endtask

  task run_for(input logic [7:0] r, input int n, input logic [7:0] s);
    wr(4'h1, r);
    repeat (n - 2) @(posedge mclk);
    wr(4'h1, s);
  endtask

  task pulse(input logic e);
    @(posedge mclk);
    ack_ext0 <= e;
    ack_ovf0 <= !e;
    @(posedge mclk);
    ack_ext0 <= 1'b0;
    ack_ovf0 <= 1'b0;
  endtask

  task chk_irq(input logic e);
    @(negedge mclk);
    chk({7'h00, irq}, {7'h00, e});
  endtask

  // Read data stand in the cycle after the strobe; compare with the oldest note.
  always @(negedge mclk)
  begin
    if (rd_d)
      chk(reg_rdata, q.pop_front());
    rd_d = reg_read;
  end

  // Cuts a hung run short.
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      summarize;
    end
  end

  initial
  begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    for (int a = 0; a < 16; a++)
      rd(a[3:0], 8'h00);
    rv = $random(seed);
    wr_rd(4'h0, {rv[7:6], 2'h2, rv[3:0]});
    wr_rd(4'h1, 8'h5A);
    wr(4'h1, 8'h00);
    // Thirteen-bit wrap raises the overflow interrupt; then mask and clear it.
    wr(4'h8, 8'h01);
    wr(4'h7, 8'h0F);
    wr(4'h0, 8'h00);
    wr(4'h3, 8'hFF);
    wr(4'h2, 8'hFF);
    run_for(8'h10, 12, 8'h20);
    rd(4'h2, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'h6, 8'h01);
    chk_irq(1'b1);
    pulse(1'b0);
    rd(4'h1, 8'h00);
    wr(4'h8, 8'h00);
    chk_irq(1'b0);
    wr(4'h8, 8'h01);
    chk_irq(1'b1);
    wr(4'h7, 8'h01);
    chk_irq(1'b0);
    // Auto-reload copies the high byte into the low byte.
    wr(4'h0, 8'h22);
    wr(4'h3, rv);
    wr(4'h2, 8'hFF);
    run_for(8'h10, 12, 8'h20);
    rd(4'h2, rv);
    // Sixteen-bit timing: five machine cycles.
    wr(4'h0, 8'h01);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    run_for(8'h10, 60, 8'h00);
    rd(4'h2, 8'h05);
    rd(4'h3, 8'h00);
    // Split mode: both bytes of unit 0 run, unit 1 holds.
    wr(4'h0, 8'h33);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h00);
    run_for(8'h50, 24, 8'h00);
    rd(4'h2, 8'h02);
    rd(4'h3, 8'h02);
    rd(4'h4, 8'h00);
    // Gated timing counts only while the pin is high.
    gate_a <= 1'b0;
    wr(4'h0, 8'h09);
    wr(4'h2, 8'h00);
    run_for(8'h10, 24, 8'h00);
    rd(4'h2, 8'h00);
    gate_a <= 1'b1;
    run_for(8'h10, 24, 8'h00);
    rd(4'h2, 8'h02);
    // Counter mode counts the falling edges of the count pin.
    rv = $random(seed);
    npulse <= {6'h00, rv[1:0]} + 8'h01;
    wr(4'h0, 8'h05);
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h10);
    pulse(1'b0);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(negedge mclk);
    for (int i = 0; i < 200 && busy !== 1'b0; i++)
      @(negedge mclk);
    repeat (36) @(posedge mclk);
    wr(4'h1, 8'h00);
    rd(4'h2, npulse);
    // Edge and level triggering of the external flag.
    for (int t = 1; t >= 0; t--)
    begin
      wr(4'h1, {7'h00, t[0]});
      gate_a <= 1'b0;
      repeat (30) @(posedge mclk);
      rd(4'h1, {6'h00, 1'b1, t[0]});
      pulse(1'b1);
      rd(4'h1, {6'h00, !t[0], t[0]});
      gate_a <= 1'b1;
      repeat (30) @(posedge mclk);
    end
    summarize;
  end
endmodule // dual_timer_counter_block_tb
